//--- cfo_regs.svh
// Offsets, field positions, codes and reset values for the
// configuration overlay command block. Included by the package and
// by the command module; holds definitions only.
`ifndef CFO_REGS_SVH
`define CFO_REGS_SVH

// Register byte offsets on the register bus, one word each; CFO_CAP_WORD_BASE is a word offset to five capability words
`define CFO_OFS_DATA      8'h00
`define CFO_OFS_FEATURE   8'h04
`define CFO_OFS_SECCNT    8'h08
`define CFO_OFS_SECNUM    8'h0C
`define CFO_OFS_CYLLOW    8'h10
`define CFO_OFS_CYLHIGH   8'h14
`define CFO_OFS_COMMAND   8'h18
`define CFO_OFS_STATE     8'h1C
`define CFO_OFS_ERROR     8'h20
`define CFO_OFS_CTRL      8'h24
`define CFO_OFS_IRQST     8'h28
`define CFO_OFS_IRQMASK   8'h2C
`define CFO_CAP_WORD_BASE 6'h0C

// Opcode and subcommand codes
`define CFO_OPC_OVERLAY   8'hB1
`define CFO_SUB_RESTORE   8'hC0
`define CFO_SUB_FREEZE    8'hC1
`define CFO_SUB_IDENTIFY  8'hC2
`define CFO_SUB_SET       8'hC3

// Field positions
`define CFO_ERR_ABT_BIT   3'd2
`define CFO_ST_BSY_BIT    3'd7
`define CFO_ST_RDY_BIT    3'd6
`define CFO_ST_DRQ_BIT    3'd3
`define CFO_ST_ERR_BIT    3'd0
`define CFO_CTRL_SRST_BIT 3'd0
`define CFO_CTRL_HPA_BIT  3'd1
`define CFO_IRQ_DONE_BIT  1'd0
`define CFO_IRQ_ABORT_BIT 1'd1

// Reset values
`define CFO_RST_STATE     8'h40
`define CFO_RST_ERROR     8'h00
`define CFO_RST_IRQMASK   2'h0

// Overlay data structure layout
`define CFO_REV_VALUE     16'h0002
`define CFO_SIG_VALUE     8'hA5
`define CFO_IDX_REV       8'h00
`define CFO_IDX_LBA_LO    8'h03
`define CFO_IDX_LBA_HI    8'h06
`define CFO_IDX_W63       8'h01
`define CFO_IDX_W82       8'h07
`define CFO_IDX_W83       8'h08
`define CFO_IDX_W84       8'h15
`define CFO_IDX_W88       8'h02

// Abort reason codes and locations
`define CFO_RSN_NONE      8'h00
`define CFO_RSN_REV       8'h01
`define CFO_RSN_SIG       8'h02
`define CFO_RSN_PROT      8'h06
`define CFO_WORD_LBA      8'h03

`endif

//--- cfo_pkg.sv
// Types shared by the configuration overlay command block.
// Assumes cfo_regs.svh is on the include path.
`include "cfo_regs.svh"

package cfo_pkg;

	// Command sequencing states
	typedef enum {
		CFO_IDLE,
		CFO_DATA_IN,
		CFO_DATA_OUT,
		CFO_CHECK
	} cfo_state_t;

	// Capability words 63, 82, 83, 84, 88 in slots 0..4
	typedef struct packed {
		logic [4:0][15:0] word;
	} cfo_caps_t;

	// Overlay received by a set, as far as it is checked
	typedef struct packed {
		logic [15:0] rev;
		logic [7:0]  sig;
		logic        lbaNz;
		cfo_caps_t   caps;
	} cfo_stage_t;

	// Outcome of checking a received overlay
	typedef struct packed {
		logic       abort;
		logic [7:0] reason;
		logic [7:0] word;
		logic [7:0] bitPos;
	} cfo_verdict_t;

endpackage : cfo_pkg

//--- cfo_overlay_check.sv
// Checks an overlay received by a set subcommand against the
// modification restrictions. Pure combinational; the caller registers.
`timescale 1ns/100ps
`default_nettype none
`include "cfo_regs.svh"

module cfo_overlay_check (
	input  wire cfo_pkg::cfo_stage_t   stage,
	input  wire logic                  hpaActive,
	output var  cfo_pkg::cfo_verdict_t verdict
);
	import cfo_pkg::*;

	// Lowest bit that differs, reported as the bit location
	function automatic logic [7:0] lowBit(input logic [15:0] v);
		logic [7:0] pos;
		pos = 8'h00;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				pos = 8'(i);
			end
		end
		return pos;
	endfunction : lowBit

	wire logic [15:0] revDiff = stage.rev ^ `CFO_REV_VALUE;
	wire logic [7:0]  sigDiff = stage.sig ^ `CFO_SIG_VALUE;

	// Protected area first: losing it would be the costliest mistake
	always_comb begin
		verdict = '0;
		if (hpaActive && stage.lbaNz) begin
			verdict.abort  = 1'b1;
			verdict.reason = `CFO_RSN_PROT;
			verdict.word   = `CFO_WORD_LBA;
		end else if (revDiff != 16'h0000) begin
			verdict.abort  = 1'b1;
			verdict.reason = `CFO_RSN_REV;
			verdict.word   = `CFO_IDX_REV;
			verdict.bitPos = lowBit(revDiff);
		end else if (sigDiff != 8'h00) begin
			verdict.abort  = 1'b1;
			verdict.reason = `CFO_RSN_SIG;
			verdict.word   = 8'hFF;
			verdict.bitPos = lowBit({8'h00, sigDiff});
		end
	end

endmodule : cfo_overlay_check
`default_nettype wire

//--- cfo_config_overlay_cmd.sv
// Configuration overlay command interpreter with a Wishbone slave
// holding the task-file registers.
// Assumes classic Wishbone on core_clk; rst_n is the power-on reset.
//
// Operation
// - Opcode B1h written to the command register selects the overlay family.
// - Feature C0h restore, C1h freeze lock, C2h identify, C3h set.
// - Restore puts back every capability removed by earlier set commands.
// - After freeze lock, every later overlay subcommand is aborted.
// - Freeze lock survives hardware and software reset; only power-down clears.
// - Identify returns a 512-byte block by PIO data-in; host reads it all. Here DATA_WORDS words, 512 bytes only at 256.
// - Identify response shows reduced set; overlay identify shows the full set.
// - Set may clear capability bits of words 63, 82, 83, 84 and 88.
// - Overlay bits not offered by the full set are ignored.
// - A set breaking a modification restriction is aborted.
// - Aborted set returns reason, word index and bit in task-file registers.
// - With a protected area, LBA-changing set or restore aborts, 06h/03h/00h.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "cfo_regs.svh"

module cfo_config_overlay_cmd #(
	parameter logic [79:0] FULL_CAPS  = {5{16'hFFFF}},
	parameter int          DATA_WORDS = 256
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              hwReset_n,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output var  logic [31:0]       wb_dat_o,
	output var  logic              wb_ack_o,
	output var  logic              irq,
	output var  logic              frozenFlag,
	output var  cfo_pkg::cfo_caps_t capWords
);
	import cfo_pkg::*;

	// The data structure must reach past the highest capability word
	if (DATA_WORDS < 32 || DATA_WORDS > 256) begin : gBadWords
		$error("DATA_WORDS must lie between 32 and 256");
	end

	localparam logic [7:0] LAST_IDX = 8'(DATA_WORDS - 1);
	localparam logic [4:0][7:0] CAP_IDX = {`CFO_IDX_W88, `CFO_IDX_W84,
		`CFO_IDX_W83, `CFO_IDX_W82, `CFO_IDX_W63};
	localparam logic [7:0] ST_DONE  = 8'(1 << `CFO_ST_RDY_BIT);
	localparam logic [7:0] ST_ABORT = ST_DONE | 8'(1 << `CFO_ST_ERR_BIT);
	localparam logic [7:0] ST_DRQ   = ST_DONE | 8'(1 << `CFO_ST_DRQ_BIT);
	localparam logic [7:0] ST_BUSY  = 8'(1 << `CFO_ST_BSY_BIT);
	localparam logic [7:0] ERR_ABT  = 8'(1 << `CFO_ERR_ABT_BIT);

	// Checksum of the full-capability structure, fixed at elaboration
	function automatic logic [7:0] csumOf(input logic [79:0] caps);
		logic [7:0] s;
		s = 8'(`CFO_REV_VALUE);
		s = s + `CFO_SIG_VALUE;
		for (int i = 0; i < 10; i++) begin
			s = s + caps[i*8 +: 8];
		end
		return 8'(~s + 8'h01);
	endfunction : csumOf

	localparam logic [7:0] CSUM = csumOf(FULL_CAPS);

	cfo_state_t    stateReg, stateNext;
	logic [7:0]    idxReg, idxNext;
	logic [7:0]    featureReg;
	logic [7:0]    secCntReg, secCntNext;
	logic [7:0]    secNumReg, secNumNext;
	logic [7:0]    cylLowReg, cylLowNext;
	logic [7:0]    cylHighReg, cylHighNext;
	logic [7:0]    errReg, errNext;
	logic [7:0]    statusReg, statusNext;
	logic          frozenReg, frozenNext;
	logic          lbaOvReg, lbaOvNext;
	cfo_caps_t     capReg, capNext;
	cfo_stage_t    stageReg;
	logic [1:0]    irqStReg, irqMaskReg;
	logic          hpaReg;
	logic          ackReg;
	logic [31:0]   datOReg;
	logic          irqReg;
	logic [2:0]    hwSync;
	logic          doneEv, abortEv;
	cfo_verdict_t  verdict;
	logic [15:0]   capIdent;

	// Hardware reset pin: three stages, asserted once stages 2 and 3 both read low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hwSync <= 3'h7;
		end else begin
			hwSync <= {hwSync[1:0], hwReset_n};
		end
	end

	// Bus decode; a request is taken only while no answer is pending
	wire logic       busReq   = wb_cyc_i & wb_stb_i & ~ackReg;
	wire logic       busWr    = busReq & wb_we_i & wb_sel_i[0];
	wire logic       busRd    = busReq & ~wb_we_i;
	wire logic [7:0] adr      = {wb_adr_i[7:2], 2'b00};
	wire logic [5:0] capOff   = wb_adr_i[7:2] - `CFO_CAP_WORD_BASE;
	wire logic       hitCap   = capOff < 6'h05;
	wire logic       hitData  = adr == `CFO_OFS_DATA;
	wire logic       dataRd   = busRd & hitData;
	wire logic       dataWr   = busWr & hitData;
	wire logic       cmdWr    = busWr & (adr == `CFO_OFS_COMMAND);
	wire logic       featWr   = busWr & (adr == `CFO_OFS_FEATURE);
	wire logic       ctrlWr   = busWr & (adr == `CFO_OFS_CTRL);
	wire logic       irqStWr  = busWr & (adr == `CFO_OFS_IRQST);
	wire logic       irqMkWr  = busWr & (adr == `CFO_OFS_IRQMASK);
	wire logic       swReset  = ctrlWr & wb_dat_i[`CFO_CTRL_SRST_BIT];
	wire logic       hwReset  = ~hwSync[1] & ~hwSync[2];
	wire logic       locReset = hwReset | swReset;
	wire logic       lastWord = idxReg == LAST_IDX;
	wire logic       isOvCmd  = cmdWr & (wb_dat_i[7:0] == `CFO_OPC_OVERLAY);

	// Overlay identify reports the full selectable set, not the reduced one
	always_comb begin
		capIdent = 16'h0000;
		for (int k = 0; k < 5; k++) begin
			if (idxReg == CAP_IDX[k]) begin
				capIdent = FULL_CAPS[k*16 +: 16];
			end
		end
	end

	wire logic [15:0] identWord =
		(idxReg == `CFO_IDX_REV) ? `CFO_REV_VALUE :
		lastWord                 ? {CSUM, `CFO_SIG_VALUE} :
		capIdent;

	// Read selection; unmapped offsets answer with zero
	wire logic [31:0] rdMux =
		hitData ? {16'h0000, identWord} :
		(adr == `CFO_OFS_FEATURE) ? {24'h000000, featureReg} :
		(adr == `CFO_OFS_SECCNT)  ? {24'h000000, secCntReg} :
		(adr == `CFO_OFS_SECNUM)  ? {24'h000000, secNumReg} :
		(adr == `CFO_OFS_CYLLOW)  ? {24'h000000, cylLowReg} :
		(adr == `CFO_OFS_CYLHIGH) ? {24'h000000, cylHighReg} :
		(adr == `CFO_OFS_STATE)   ? {24'h000000, statusReg} :
		(adr == `CFO_OFS_ERROR)   ? {24'h000000, errReg} :
		(adr == `CFO_OFS_CTRL)    ? {30'h0, hpaReg, 1'b0} :
		(adr == `CFO_OFS_IRQST)   ? {30'h0, irqStReg} :
		(adr == `CFO_OFS_IRQMASK) ? {30'h0, irqMaskReg} :
		hitCap ? {16'h0000, capReg.word[capOff[2:0]]} :
		32'h00000000;

	cfo_overlay_check uCheck (
		.stage     (stageReg),
		.hpaActive (hpaReg),
		.verdict   (verdict)
	);

	// Command sequencing; results land in the task-file registers
	always_comb begin
		stateNext   = stateReg;
		idxNext     = idxReg;
		secCntNext  = secCntReg;
		secNumNext  = secNumReg;
		cylLowNext  = cylLowReg;
		cylHighNext = cylHighReg;
		errNext     = errReg;
		statusNext  = statusReg;
		frozenNext  = frozenReg;
		lbaOvNext   = lbaOvReg;
		capNext     = capReg;
		doneEv      = 1'b0;
		abortEv     = 1'b0;
		unique case (stateReg)
			CFO_IDLE: begin
				if (isOvCmd) begin
					secCntNext  = 8'h00;
					secNumNext  = 8'h00;
					cylLowNext  = 8'h00;
					cylHighNext = 8'h00;
					errNext     = 8'h00;
					statusNext  = ST_DONE;
					doneEv      = 1'b1;
					if (frozenReg) begin
						doneEv     = 1'b0;
						abortEv    = 1'b1;
					end else if (featureReg == `CFO_SUB_RESTORE) begin
						if (hpaReg && lbaOvReg) begin
							doneEv      = 1'b0;
							abortEv     = 1'b1;
							secCntNext  = `CFO_RSN_PROT;
							cylHighNext = `CFO_WORD_LBA;
						end else begin
							capNext   = FULL_CAPS;
							lbaOvNext = 1'b0;
						end
					end else if (featureReg == `CFO_SUB_FREEZE) begin
						frozenNext = 1'b1;
					end else if (featureReg == `CFO_SUB_IDENTIFY) begin
						doneEv     = 1'b0;
						stateNext  = CFO_DATA_IN;
						idxNext    = 8'h00;
						statusNext = ST_DRQ;
					end else if (featureReg == `CFO_SUB_SET) begin
						doneEv     = 1'b0;
						stateNext  = CFO_DATA_OUT;
						idxNext    = 8'h00;
						statusNext = ST_DRQ;
					end else begin
						doneEv     = 1'b0;
						abortEv    = 1'b1;
					end
				end
			end
			CFO_DATA_IN: begin
				if (dataRd) begin
					idxNext = idxReg + 8'h01;
					if (lastWord) begin
						stateNext  = CFO_IDLE;
						statusNext = ST_DONE;
						doneEv     = 1'b1;
					end
				end
			end
			CFO_DATA_OUT: begin
				if (dataWr) begin
					idxNext = idxReg + 8'h01;
					if (lastWord) begin
						stateNext  = CFO_CHECK;
						statusNext = ST_BUSY;
					end
				end
			end
			CFO_CHECK: begin
				stateNext = CFO_IDLE;
				if (verdict.abort) begin
					abortEv     = 1'b1;
					secCntNext  = verdict.reason;
					cylHighNext = verdict.word;
					cylLowNext  = verdict.bitPos;
				end else begin
					// Only bits the full set offers can stay set
					capNext    = stageReg.caps & FULL_CAPS;
					lbaOvNext  = lbaOvReg | stageReg.lbaNz;
					statusNext = ST_DONE;
					doneEv     = 1'b1;
				end
			end
		endcase
		if (abortEv) begin
			statusNext = ST_ABORT;
			errNext    = ERR_ABT;
		end
		// Resets abandon a command; the lock is held over them
		if (locReset) begin
			stateNext  = CFO_IDLE;
			statusNext = `CFO_RST_STATE;
			errNext    = `CFO_RST_ERROR;
			doneEv     = 1'b0;
			abortEv    = 1'b0;
		end
	end

	// Command state registers; only power-on clears the lock
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateReg   <= CFO_IDLE;
			idxReg     <= 8'h00;
			secCntReg  <= 8'h00;
			secNumReg  <= 8'h00;
			cylLowReg  <= 8'h00;
			cylHighReg <= 8'h00;
			errReg     <= `CFO_RST_ERROR;
			statusReg  <= `CFO_RST_STATE;
			frozenReg  <= 1'b0;
			lbaOvReg   <= 1'b0;
			capReg     <= FULL_CAPS;
		end else begin
			stateReg   <= stateNext;
			idxReg     <= idxNext;
			secCntReg  <= secCntNext;
			secNumReg  <= secNumNext;
			cylLowReg  <= cylLowNext;
			cylHighReg <= cylHighNext;
			errReg     <= errNext;
			statusReg  <= statusNext;
			frozenReg  <= frozenNext;
			lbaOvReg   <= lbaOvNext;
			capReg     <= capNext;
		end
	end

	// Host-written registers; feature is ignored while a command runs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			featureReg <= 8'h00;
			hpaReg     <= 1'b0;
			irqMaskReg <= `CFO_RST_IRQMASK;
		end else begin
			if (featWr && stateReg == CFO_IDLE) begin
				featureReg <= wb_dat_i[7:0];
			end
			if (ctrlWr) begin
				hpaReg <= wb_dat_i[`CFO_CTRL_HPA_BIT];
			end
			if (irqMkWr) begin
				irqMaskReg <= wb_dat_i[1:0];
			end
		end
	end

	// Received overlay, captured word by word during the data-out phase
	wire logic inSet  = dataWr & (stateReg == CFO_DATA_OUT);
	wire logic lbaHit = idxReg >= `CFO_IDX_LBA_LO &&
		idxReg <= `CFO_IDX_LBA_HI;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stageReg.rev   <= 16'h0000;
			stageReg.sig   <= 8'h00;
			stageReg.lbaNz <= 1'b0;
		end else if (inSet) begin
			if (idxReg == `CFO_IDX_REV) begin
				stageReg.rev   <= wb_dat_i[15:0];
				stageReg.lbaNz <= 1'b0;
			end
			if (lastWord) begin
				stageReg.sig <= wb_dat_i[7:0];
			end
			if (lbaHit && wb_dat_i[15:0] != 16'h0000) begin
				stageReg.lbaNz <= 1'b1;
			end
		end
	end

	// One capture register per capability word
	for (genvar g = 0; g < 5; g++) begin : gCap
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				stageReg.caps.word[g] <= 16'h0000;
			end else if (inSet && idxReg == CAP_IDX[g]) begin
				stageReg.caps.word[g] <= wb_dat_i[15:0];
			end
		end
	end

	// Sticky events, write one to clear; a new event beats the clear
	wire logic [1:0] irqEvents = {abortEv, doneEv};
	wire logic [1:0] irqClr    = irqStWr ? wb_dat_i[1:0] : 2'b00;
	wire logic [1:0] irqStNext = (irqStReg & ~irqClr) | irqEvents;

	// Bus answer one cycle after the request; outputs all registered
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irqStReg <= 2'b00;
			irqReg   <= 1'b0;
			ackReg   <= 1'b0;
			datOReg  <= 32'h00000000;
		end else begin
			irqStReg <= irqStNext;
			irqReg   <= |(irqStNext & irqMaskReg);
			ackReg   <= busReq;
			if (busRd) begin
				datOReg <= rdMux;
			end
		end
	end

	assign wb_dat_o   = datOReg;
	assign wb_ack_o   = ackReg;
	assign irq        = irqReg;
	assign frozenFlag = frozenReg;
	assign capWords   = capReg;

endmodule : cfo_config_overlay_cmd
`default_nettype wire

//--- cfo_config_overlay_cmd_assertions.sv
// Checker for the overlay command block, bound to its top module.
// Assumes single-request Wishbone masters and the core_clk domain only.
`timescale 1ns/100ps
`default_nettype none
`include "cfo_regs.svh"

module cfo_config_overlay_cmd_assertions #(
	parameter logic [79:0] FULL_CAPS  = {5{16'hFFFF}},
	parameter int          DATA_WORDS = 256
) (
	input wire logic               core_clk,
	input wire logic               rst_n,
	input wire logic               hwReset_n,
	input wire logic               wb_cyc_i,
	input wire logic               wb_stb_i,
	input wire logic               wb_we_i,
	input wire logic [7:0]         wb_adr_i,
	input wire logic [3:0]         wb_sel_i,
	input wire logic [31:0]        wb_dat_i,
	input wire logic [31:0]        wb_dat_o,
	input wire logic               wb_ack_o,
	input wire logic               irq,
	input wire logic               frozenFlag,
	input wire cfo_pkg::cfo_caps_t capWords
);
	import cfo_pkg::*;

	logic [7:0] featReg;
	logic       hpaReg;
	wire        reqTaken = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire        wrTaken  = reqTaken && wb_we_i && wb_sel_i[0];
	wire [7:0]  wordAdr  = {wb_adr_i[7:2], 2'b00};
	wire        cmdOvl   = wrTaken && wordAdr == `CFO_OFS_COMMAND
		&& wb_dat_i[7:0] == `CFO_OPC_OVERLAY;
	wire        frzCmd   = cmdOvl && featReg == `CFO_SUB_FREEZE;

	// Shadow of feature and protected-area bit; feature writes while busy
	// are not filtered here, so stimulus writes features only when idle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			featReg <= 8'h00;
			hpaReg  <= 1'b0;
		end else if (wrTaken && wordAdr == `CFO_OFS_FEATURE) begin
			featReg <= wb_dat_i[7:0];
		end else if (wrTaken && wordAdr == `CFO_OFS_CTRL) begin
			hpaReg  <= wb_dat_i[1];
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_ackPulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_ackAfterReq; reqTaken |=> wb_ack_o; endproperty
	property p_readHold;
		!(reqTaken && !wb_we_i) |=> $stable(wb_dat_o);
	endproperty
	property p_freezeSticky; frozenFlag |=> frozenFlag; endproperty
	property p_freezeCause;
		$rose(frozenFlag) |-> $past(frzCmd);
	endproperty
	property p_frozenCaps; frozenFlag |=> $stable(capWords); endproperty
	property p_capsWithin; (capWords & ~FULL_CAPS) == 80'h0; endproperty
	property p_restoreFull;
		cmdOvl && featReg == `CFO_SUB_RESTORE && !frozenFlag && !hpaReg
			|=> capWords == FULL_CAPS;
	endproperty

	a_ackPulse: assert property (p_ackPulse)
		else $error("ack held longer than one cycle");
	a_ackAfterReq: assert property (p_ackAfterReq)
		else $error("request not answered in the next cycle");
	a_readHold: assert property (p_readHold)
		else $error("read data changed without a read");
	a_freezeSticky: assert property (p_freezeSticky)
		else $error("freeze lock lost without power-down");
	a_freezeCause: assert property (p_freezeCause)
		else $error("freeze lock set without a freeze command");
	a_frozenCaps: assert property (p_frozenCaps)
		else $error("capabilities changed while frozen");
	a_capsWithin: assert property (p_capsWithin)
		else $error("capability outside the full set");
	a_restoreFull: assert property (p_restoreFull)
		else $error("restore did not bring back the full set");

	// Main scenarios reached
	c_freeze: cover property ($rose(frozenFlag));
	c_capsDrop: cover property (!$stable(capWords));
	c_irq: cover property ($rose(irq));
endmodule : cfo_config_overlay_cmd_assertions

bind cfo_config_overlay_cmd cfo_config_overlay_cmd_assertions #(
	.FULL_CAPS(FULL_CAPS),
	.DATA_WORDS(DATA_WORDS)
) chk_u (
	.core_clk(core_clk), .rst_n(rst_n), .hwReset_n(hwReset_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
	.frozenFlag(frozenFlag), .capWords(capWords)
);
`default_nettype wire

//--- cfo_host_model.sv
// Host side model: a classic Wishbone master issuing overlay commands.
// Assumes a slave that acks every request; hangs are cut by the bench.
`timescale 1ns/100ps
`default_nettype none
`include "cfo_regs.svh"

module cfo_host_model (
	input  wire logic        core_clk,
	input  wire logic        ack,
	input  wire logic [31:0] rdat,
	output var  logic        cyc,
	output var  logic        stb,
	output var  logic        we,
	output var  logic [7:0]  adr,
	output var  logic [3:0]  sel,
	output var  logic [31:0] wdat
);
	logic [15:0] blk [256];

	initial begin
		{cyc, stb, we, adr, sel, wdat} = '0;
	end

	// Request held until ack is sampled; released data is inverted
	task automatic wbXfer(input logic w, input logic [7:0] a,
		input logic [15:0] d, output logic [31:0] q);
		@(posedge core_clk);
		{cyc, stb, we, adr, sel} <= {1'b1, 1'b1, w, a, 4'hF};
		wdat <= {16'h0000, d};
		do @(posedge core_clk); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb, we} <= 3'b000;
		wdat <= ~{16'h0000, d};
	endtask : wbXfer

	task automatic wbWrite(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		wbXfer(1'b1, a, d, q);
	endtask : wbWrite

	task automatic wbRead(input logic [7:0] a, output logic [31:0] q);
		wbXfer(1'b0, a, 16'h0000, q);
	endtask : wbRead

	// Feature first, then the overlay opcode
	task automatic issueCmd(input logic [7:0] f);
		wbWrite(`CFO_OFS_FEATURE, {8'h00, f});
		wbWrite(`CFO_OFS_COMMAND, {8'h00, `CFO_OPC_OVERLAY});
	endtask : issueCmd

	// Overlay word; checksum left zero, LBA high byte spoils the signature
	function automatic logic [15:0] ovWord(input int i, input logic [15:0] rev,
		input logic [15:0] lba, input logic [79:0] c);
		case (i)
			0: return rev;
			1: return c[15:0];
			2: return c[79:64];
			3: return lba;
			7: return c[31:16];
			8: return c[47:32];
			21: return c[63:48];
			255: return {8'h00, 8'hA5 ^ lba[15:8]};
			default: return 16'h0000;
		endcase
	endfunction : ovWord

	task automatic sendBlock(input logic [15:0] rev, input logic [15:0] lba,
		input logic [79:0] c);
		for (int i = 0; i < 256; i++) begin
			wbWrite(`CFO_OFS_DATA, ovWord(i, rev, lba, c));
		end
	endtask : sendBlock

	// The whole 512-byte block is taken, never cut short
	task automatic readBlock;
		logic [31:0] q;
		for (int i = 0; i < 256; i++) begin
			wbRead(`CFO_OFS_DATA, q);
			blk[i] = q[15:0];
		end
	endtask : readBlock
endmodule : cfo_host_model
`default_nettype wire

//--- cfo_config_overlay_cmd_tb.sv
// Self-checking bench for the overlay command block.
// Assumes the host model as the only bus master; one clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "cfo_regs.svh"

module cfo_config_overlay_cmd_tb;
	import cfo_pkg::*;
	// Full set is not all ones, so ignored overlay bits show
	localparam logic [79:0] FULL = {16'h001F, 16'h2200, 16'h7F0F,
		16'h3C3F, 16'h0007};
	localparam logic [79:0] ALL1 = {5{16'hFFFF}};
	localparam logic [79:0] SENT = {16'hFFFE, 16'hFDFF, 16'hFFF0,
		16'hFFFF, 16'hFFFB};
	logic        core_clk, rst_n, hwReset_n, cyc, stb, we, ack, irq, frz;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	cfo_caps_t   capWords;
	int          errTotal = 0;
	int          testsRun = 0;

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	cfo_host_model host_u (.core_clk(core_clk), .ack(ack), .rdat(rdat),
		.cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .wdat(wdat));
	cfo_config_overlay_cmd #(.FULL_CAPS(FULL), .DATA_WORDS(256)) dut_u (
		.core_clk(core_clk), .rst_n(rst_n), .hwReset_n(hwReset_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.irq(irq), .frozenFlag(frz), .capWords(capWords));

	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		testsRun++;
		if (got !== exp) begin
			errTotal++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		host_u.wbRead(a, v);
		chk(v, exp);
	endtask : rdChk

	task automatic abortChk(input logic [7:0] rsn, input logic [7:0] w,
		input logic [7:0] b);
		rdChk(`CFO_OFS_STATE, 32'h41);
		rdChk(`CFO_OFS_ERROR, 32'h04);
		rdChk(`CFO_OFS_SECCNT, rsn);
		rdChk(`CFO_OFS_CYLHIGH, w);
		rdChk(`CFO_OFS_CYLLOW, b);
	endtask : abortChk

	// Set subcommand, then poll until busy drops, bounded
	task automatic setCmd(input logic [15:0] rev, input logic [15:0] lba,
		input logic [79:0] c);
		logic [31:0] v;
		host_u.issueCmd(`CFO_SUB_SET);
		rdChk(`CFO_OFS_STATE, 32'h48);
		host_u.sendBlock(rev, lba, c);
		v = 32'h80;
		for (int n = 0; n < 8 && v[7] !== 1'b0; n++) begin
			host_u.wbRead(`CFO_OFS_STATE, v);
		end
		chk(v[7], 1'b0);
	endtask : setCmd

	// Overlay identify always reports the full set
	task automatic idCheck;
		host_u.issueCmd(`CFO_SUB_IDENTIFY);
		rdChk(`CFO_OFS_STATE, 32'h48);
		host_u.readBlock();
		for (int i = 0; i < 255; i++) begin
			chk(host_u.blk[i], host_u.ovWord(i, 16'h0002, 16'h0, FULL));
		end
		chk(host_u.blk[255][7:0], 8'hA5);
		rdChk(`CFO_OFS_STATE, 32'h40);
	endtask : idCheck

	task automatic finalReport;
		$display("Comparisons %0d, mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finalReport

	// About 7.4k cycles expected; generous margin
	initial begin
		#(8 * 60000);
		errTotal++;
		finalReport();
	end

	initial begin
		rst_n = 1'b0;
		hwReset_n = 1'b1;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		rdChk(`CFO_OFS_STATE, 32'h40);
		rdChk(`CFO_OFS_IRQMASK, 32'h0);
		rdChk(8'h7C, 32'h0);
		rdChk(8'h30, FULL[15:0]);
		host_u.wbWrite(`CFO_OFS_IRQMASK, 16'h2);
		host_u.issueCmd(8'hC4);
		abortChk(8'h00, 8'h00, 8'h00);
		chk(irq, 1'b1);
		host_u.wbWrite(`CFO_OFS_IRQST, 16'h2);
		rdChk(`CFO_OFS_IRQST, 32'h0);
		chk(irq, 1'b0);
		host_u.wbWrite(`CFO_OFS_IRQMASK, 16'h0);
		host_u.issueCmd(8'h00);
		rdChk(`CFO_OFS_IRQST, 32'h2);
		chk(irq, 1'b0);
		host_u.wbWrite(`CFO_OFS_IRQMASK, 16'h2);
		rdChk(`CFO_OFS_IRQMASK, 32'h2);
		chk(irq, 1'b1);
		host_u.wbWrite(`CFO_OFS_IRQST, 16'h2);
		// Wrong opcode must not start identify
		host_u.wbWrite(`CFO_OFS_FEATURE, {8'h00, `CFO_SUB_IDENTIFY});
		host_u.wbWrite(`CFO_OFS_COMMAND, 16'h00EC);
		rdChk(`CFO_OFS_STATE, 32'h41);
		idCheck();
		rdChk(`CFO_OFS_IRQST, 32'h1);
		host_u.wbWrite(`CFO_OFS_IRQST, 16'h1);
		setCmd(16'h0002, 16'h0000, SENT);
		rdChk(`CFO_OFS_STATE, 32'h40);
		chk(capWords, SENT & FULL);
		rdChk(8'h34, SENT[31:16] & FULL[31:16]);
		idCheck();
		setCmd(16'h0006, 16'h0000, ALL1);
		abortChk(8'h01, 8'h00, 8'h02);
		setCmd(16'h0002, 16'h0100, ALL1);
		abortChk(8'h02, 8'hFF, 8'h00);
		chk(capWords, SENT & FULL);
		setCmd(16'h0002, 16'h0010, ALL1);
		chk(capWords, FULL);
		host_u.wbWrite(`CFO_OFS_CTRL, 16'h2);
		setCmd(16'h0002, 16'h0001, SENT);
		abortChk(8'h06, 8'h03, 8'h00);
		rdChk(`CFO_OFS_SECNUM, 32'h0);
		chk(capWords, FULL);
		host_u.issueCmd(`CFO_SUB_RESTORE);
		abortChk(8'h06, 8'h03, 8'h00);
		host_u.wbWrite(`CFO_OFS_CTRL, 16'h0);
		setCmd(16'h0002, 16'h0000, SENT);
		chk(capWords, SENT & FULL);
		host_u.issueCmd(`CFO_SUB_RESTORE);
		rdChk(`CFO_OFS_STATE, 32'h40);
		chk(capWords, FULL);
		setCmd(16'h0002, 16'h0000, SENT);
		host_u.issueCmd(`CFO_SUB_FREEZE);
		chk(frz, 1'b1);
		host_u.issueCmd(8'hC7);
		abortChk(8'h00, 8'h00, 8'h00);
		host_u.wbWrite(`CFO_OFS_CTRL, 16'h1);
		rdChk(`CFO_OFS_STATE, 32'h40);
		chk(frz, 1'b1);
		host_u.issueCmd(`CFO_SUB_RESTORE);
		rdChk(`CFO_OFS_STATE, 32'h41);
		@(posedge core_clk);
		hwReset_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		hwReset_n <= 1'b1;
		repeat (5) @(posedge core_clk);
		rdChk(`CFO_OFS_STATE, 32'h40);
		chk(frz, 1'b1);
		for (int f = 8'hC0; f <= 8'hC3; f++) begin
			host_u.issueCmd(f[7:0]);
			abortChk(8'h00, 8'h00, 8'h00);
			chk(capWords, SENT & FULL);
		end
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		chk(frz, 1'b0);
		chk(capWords, FULL);
		finalReport();
	end
endmodule : cfo_config_overlay_cmd_tb
`default_nettype wire
